// ===== rtl/dqmt_channel.sv
/*
  one test channel: write pass, flush wait, read-back compare.
  assumes a controller port with ready handshake and in-order read data.
*/
`timescale 1ns/1ns
`include "dqmt_defs.svh"
module dqmt_channel
(
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire logic                     start,
  input  wire logic                     quick,
  output logic                          busy,
  output logic                          pass,
  output logic                          mem_write,
  output logic                          mem_read,
  output logic [`DQMT_ADDR_W-1:0]       mem_addr,
  output logic [`DQMT_DATA_W-1:0]       mem_wdata,
  input  wire logic                     mem_ready,
  input  wire logic                     mem_wr_idle,
  input  wire logic                     mem_rvalid,
  input  wire logic [`DQMT_DATA_W-1:0]  mem_rdata
);
  dqmt_pkg::dqmt_state_e st_q, st_d;
  logic [`DQMT_ADDR_W-1:0] addr_q, addr_d, cmp_q, cmp_d;
  logic                    ok_q, ok_d, qk_q, qk_d;
  logic [`DQMT_ADDR_W-1:0] last;
  logic                    last_cmp;

  // address-in-data pattern toggles every data line but the four fixed-high middle ones; quick uses a constant
  function automatic logic [`DQMT_DATA_W-1:0] pat(
    input logic [`DQMT_ADDR_W-1:0] a, input logic q);
    pat = q ? `DQMT_QUICK_PAT
            : {~a, 4'hF, a};
  endfunction

  assign last     = qk_q ? `DQMT_QUICK_LAST : `DQMT_LAST_ADDR;
  assign last_cmp = (cmp_q == last);

  always_comb
  begin
    st_d   = st_q;
    addr_d = addr_q;
    cmp_d  = cmp_q;
    ok_d   = ok_q;
    qk_d   = qk_q;
    case (st_q)
      dqmt_pkg::DQMT_IDLE, dqmt_pkg::DQMT_DONE:
        if (start)
        begin
          st_d   = dqmt_pkg::DQMT_WRITE;
          addr_d = '0;
          cmp_d  = '0;
          ok_d   = 1'b1;
          qk_d   = quick;
        end
      dqmt_pkg::DQMT_WRITE:
        if (mem_ready)
        begin
          addr_d = addr_q + 1'b1;
          if (addr_q == last)
          begin
            st_d   = dqmt_pkg::DQMT_FLUSH;
            addr_d = '0;
          end
        end
      dqmt_pkg::DQMT_FLUSH:
        // no read may start until every write has reached the memory
        if (mem_wr_idle)
          st_d = dqmt_pkg::DQMT_READ;
      dqmt_pkg::DQMT_READ:
      begin
        if (mem_ready && addr_q != last)
          addr_d = addr_q + 1'b1;
        if (mem_rvalid)
        begin
          if (mem_rdata != pat(cmp_q, qk_q))
            ok_d = 1'b0;
          cmp_d = cmp_q + 1'b1;
          if (last_cmp)
            st_d = dqmt_pkg::DQMT_DONE;
        end
      end
      default:
        st_d = dqmt_pkg::DQMT_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q   <= dqmt_pkg::DQMT_IDLE;
      addr_q <= '0;
      cmp_q  <= '0;
      ok_q   <= 1'b0;
      qk_q   <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      addr_q <= addr_d;
      cmp_q  <= cmp_d;
      ok_q   <= ok_d;
      qk_q   <= qk_d;
    end
  end

  logic rd_issued_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_issued_q <= 1'b0;
    else if (st_q != dqmt_pkg::DQMT_READ)
      rd_issued_q <= 1'b0;
    else if (mem_ready && addr_q == last)
      rd_issued_q <= 1'b1;
  end

  assign busy      = (st_q == dqmt_pkg::DQMT_WRITE) ||
                     (st_q == dqmt_pkg::DQMT_FLUSH) ||
                     (st_q == dqmt_pkg::DQMT_READ);
  assign pass      = (st_q == dqmt_pkg::DQMT_DONE) && ok_q;
  assign mem_write = (st_q == dqmt_pkg::DQMT_WRITE);
  assign mem_read  = (st_q == dqmt_pkg::DQMT_READ) && !rd_issued_q;
  assign mem_addr  = addr_q;
  assign mem_wdata = pat(addr_q, qk_q);

  flush_before_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    mem_read |-> $past(mem_wr_idle) || $past(mem_read))
    else $error("read issued before writes drained");
  start_launch_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!busy && start) |=> mem_write && mem_addr == '0)
    else $error("start did not launch a write pass");
endmodule

// ===== rtl/dqmt_defs.svh
/*
  timing counts and test geometry for the quad memory tester.
  assumes a 250 MHz core clock; included by bare name.
*/
`ifndef DQMT_DEFS_SVH
`define DQMT_DEFS_SVH
`define DQMT_CLK_MHZ        250
`define DQMT_RUN_MS         1000
`define DQMT_RUN_CYC        (`DQMT_RUN_MS * 1000 * `DQMT_CLK_MHZ)
`define DQMT_BLINK_MS       100
`define DQMT_BLINK_CYC      (`DQMT_BLINK_MS * 1000 * `DQMT_CLK_MHZ)
// 2^30 words of 64 bits fill one whole 8 GB module
`define DQMT_ADDR_W         30
`define DQMT_DATA_W         64
`define DQMT_LAST_ADDR      30'h3FFFFFFF
`define DQMT_QUICK_LAST     30'h000001A
`define DQMT_QUICK_PAT      64'hA5A5A5A55A5A5A5A
`endif

// ===== rtl/dqmt_pkg.sv
/*
  shared types of the quad memory tester.
  assumes nothing of its surroundings.
*/
package dqmt_pkg;
  typedef enum logic [2:0]
  {
    DQMT_IDLE  = 3'h0,
    DQMT_WRITE = 3'h1,
    DQMT_FLUSH = 3'h3,
    DQMT_READ  = 3'h2,
    DQMT_DONE  = 3'h6
  } dqmt_state_e;
endpackage

// ===== rtl/dqmt_top.sv
/*
  quad memory tester top: key synchroniser, four channels, lamps.
  assumes four memory controllers already calibrated and self-refreshing.
*/
`timescale 1ns/1ns
`include "dqmt_defs.svh"
// Functional notes
// - four independent channels, each on its own controller and socket
// - start key press launches write then read-back verify
// - a full-array run takes at least 2^31 cycles, about 8.6 seconds at 250 MHz
// - lamps blink while a run is in progress
// - after the run a passing channel lamp stays lit
// - after the run a mismatching channel lamp stays dark
// - lamp order follows socket order, A first
// - a later press regenerates control and runs again
// - write whole array, flush, then read and compare all
// - quick option writes a constant pattern and reads it back
module dqmt_top
#(
  parameter int unsigned RUN_CYC   = `DQMT_RUN_CYC,
  parameter int unsigned BLINK_CYC = `DQMT_BLINK_CYC
)
(
  // core clock arrives already multiplied up; no clock logic inside
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire logic                         test_start_key_n,
  input  wire logic                         quick_sel,
  output logic                              result_lamp_socket_a,
  output logic                              result_lamp_socket_b,
  output logic                              result_lamp_socket_c,
  output logic                              result_lamp_socket_d,
  output logic [3:0]                        mem_write,
  output logic [3:0]                        mem_read,
  output logic [4*`DQMT_ADDR_W-1:0]         mem_addr,
  output logic [4*`DQMT_DATA_W-1:0]         mem_wdata,
  input  wire logic [3:0]                   mem_ready,
  input  wire logic [3:0]                   mem_wr_idle,
  input  wire logic [3:0]                   mem_rvalid,
  input  wire logic [4*`DQMT_DATA_W-1:0]    mem_rdata
);
  logic [2:0]  key_q, key_d;
  logic        qs1_q, qs2_q;
  logic        press;
  logic [31:0] run_q, run_d, blk_q, blk_d;
  logic        blink_q, blink_d;
  logic [3:0]  busy, pass, lamp;
  logic        run_quick_q, run_quick_d;

  // two stages of synchroniser, third is the edge history
  always_comb
  begin
    key_d = {key_q[1:0], ~test_start_key_n};
  end
  assign press = key_q[1] && !key_q[2];

  // time-keeping: blink rate and nominal run window
  always_comb
  begin
    run_d   = run_q;
    blk_d   = blk_q;
    blink_d = blink_q;
    if (|busy)
    begin
      if (run_q != RUN_CYC - 1)
        run_d = run_q + 32'h00000001;
      if (blk_q == BLINK_CYC - 1)
      begin
        blk_d   = '0;
        blink_d = ~blink_q;
      end
      else
        blk_d = blk_q + 32'h00000001;
    end
    else
    begin
      blk_d   = '0;
      blink_d = 1'b1;
      if (press)
        run_d = '0;
    end
  end

  // mode copy for the pattern checks; channels keep their own
  always_comb
  begin
    run_quick_d = run_quick_q;
    if (press && !(|busy))
      run_quick_d = qs2_q;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      key_q   <= 3'h0;
      qs1_q   <= 1'b0;
      qs2_q   <= 1'b0;
      run_q   <= '0;
      blk_q   <= '0;
      blink_q <= 1'b1;
      run_quick_q <= 1'b0;
    end
    else
    begin
      key_q   <= key_d;
      qs1_q   <= quick_sel;
      qs2_q   <= qs1_q;
      run_q   <= run_d;
      blk_q   <= blk_d;
      blink_q <= blink_d;
      run_quick_q <= run_quick_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_ch
      // per-channel views, read only by the checks below
      logic [`DQMT_ADDR_W-1:0] ch_addr;
      logic [`DQMT_DATA_W-1:0] ch_wdata;
      assign ch_addr  = mem_addr[g*`DQMT_ADDR_W +: `DQMT_ADDR_W];
      assign ch_wdata = mem_wdata[g*`DQMT_DATA_W +: `DQMT_DATA_W];
      dqmt_channel u_ch
      (
        .clk         (clk),
        .arst_n      (arst_n),
        .start       (press && !(|busy)),
        .quick       (qs2_q),
        .busy        (busy[g]),
        .pass        (pass[g]),
        .mem_write   (mem_write[g]),
        .mem_read    (mem_read[g]),
        .mem_addr    (mem_addr[g*`DQMT_ADDR_W +: `DQMT_ADDR_W]),
        .mem_wdata   (mem_wdata[g*`DQMT_DATA_W +: `DQMT_DATA_W]),
        .mem_ready   (mem_ready[g]),
        .mem_wr_idle (mem_wr_idle[g]),
        .mem_rvalid  (mem_rvalid[g]),
        .mem_rdata   (mem_rdata[g*`DQMT_DATA_W +: `DQMT_DATA_W])
      );
      // blinking while busy, then steady from the latched outcome
      assign lamp[g] = busy[g] ? blink_q : pass[g];

      lamp_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
        !busy[g] |-> lamp[g] == pass[g])
        else $error("idle lamp does not show the latched outcome");
      one_dir_a: assert property (@(posedge clk) disable iff (!arst_n)
        !(mem_write[g] && mem_read[g]))
        else $error("write and read requested together");
      quick_pat_a: assert property (@(posedge clk) disable iff (!arst_n)
        (mem_write[g] && run_quick_q) |-> ch_wdata == `DQMT_QUICK_PAT)
        else $error("quick pass wrote a varying pattern");
      full_pat_a: assert property (@(posedge clk) disable iff (!arst_n)
        (mem_write[g] && !run_quick_q) |->
          ch_wdata == {~ch_addr, 4'hF, ch_addr})
        else $error("full pass pattern does not follow address");
      quick_span_a: assert property (@(posedge clk) disable iff (!arst_n)
        (busy[g] && run_quick_q) |-> ch_addr <= `DQMT_QUICK_LAST)
        else $error("quick pass left its address span");
      rerun_addr_a: assert property (@(posedge clk) disable iff (!arst_n)
        (press && !(|busy)) |=> ch_addr == '0)
        else $error("fresh run did not restart at address zero");
      pass_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!busy[g] && !press) |=> $stable(pass[g]))
        else $error("idle outcome changed without a press");
    end
  endgenerate

  assign result_lamp_socket_a = lamp[0];
  assign result_lamp_socket_b = lamp[1];
  assign result_lamp_socket_c = lamp[2];
  assign result_lamp_socket_d = lamp[3];

  lamp_blink_a: assert property (@(posedge clk) disable iff (!arst_n)
    busy[0] |-> result_lamp_socket_a == blink_q)
    else $error("socket a lamp not blinking during run");
  lamp_pass_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!busy[1] && pass[1]) |-> result_lamp_socket_b)
    else $error("passing channel lamp dark");
  lamp_fail_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!busy[2] && !pass[2]) |-> !result_lamp_socket_c)
    else $error("failing channel lamp lit");
  lamp_static_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!(|busy) && !press) |=> $stable(lamp))
    else $error("idle lamps changed without a press");
  press_start_a: assert property (@(posedge clk) disable iff (!arst_n)
    (press && !(|busy)) |=> &busy)
    else $error("press did not start all channels");
  rerun_a: assert property (@(posedge clk) disable iff (!arst_n)
    (press && !(|busy) && |pass) |=> !(|pass))
    else $error("repeat run kept old outcome");
  sync_edge_a: assert property (@(posedge clk) disable iff (!arst_n)
    press |-> ##1 !press)
    else $error("press lasted over one cycle");
  socket_order_a: assert property (@(posedge clk) disable iff (!arst_n)
    !busy[3] |-> result_lamp_socket_d == pass[3])
    else $error("socket d lamp not tied to channel d");
  run_cap_a: assert property (@(posedge clk) disable iff (!arst_n)
    run_q < RUN_CYC)
    else $error("run counter overran");
  run_start_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(|busy) |-> run_q == 32'h00000000)
    else $error("run window did not restart with the run");
  blink_rate_a: assert property (@(posedge clk) disable iff (!arst_n)
    (|busy && blk_q == BLINK_CYC - 1) |=> $changed(blink_q))
    else $error("lamp blink period not kept");

  run_cov: cover property (@(posedge clk) disable iff (!arst_n)
    press ##1 (|busy));
  pass_cov: cover property (@(posedge clk) disable iff (!arst_n)
    $fell(busy[0]) && pass[0]);
  fail_cov: cover property (@(posedge clk) disable iff (!arst_n)
    $fell(busy[0]) && !pass[0]);
  quick_cov: cover property (@(posedge clk) disable iff (!arst_n)
    press && qs2_q);
  split_cov: cover property (@(posedge clk) disable iff (!arst_n)
    $fell(busy[0]) && busy[1]);
endmodule

// ===== tb/dqmt_mem_model.sv
/*
  behavioural four-channel memory controller for the tester bench.
  assumes the tester holds requests until ready; bad flips bit 0 of word 5.
*/
`timescale 1ns/1ns
`include "dqmt_defs.svh"
module dqmt_mem_model
(
  input  wire logic [0:0]                clk,
  input  wire logic                      slow,
  input  wire logic [3:0]                bad,
  input  wire logic [3:0]                mem_write,
  input  wire logic [3:0]                mem_read,
  input  wire logic [4*`DQMT_ADDR_W-1:0] mem_addr,
  input  wire logic [4*`DQMT_DATA_W-1:0] mem_wdata,
  output logic      [3:0]                mem_ready,
  output logic      [3:0]                mem_wr_idle,
  output logic      [3:0]                mem_rvalid,
  output logic      [4*`DQMT_DATA_W-1:0] mem_rdata
);
  localparam int AW = `DQMT_ADDR_W;
  localparam int DW = `DQMT_DATA_W;
  logic [DW-1:0] store [longint];
  logic [DW-1:0] pipe  [4];
  logic [3:0]    pv;
  int            quiet [4];
  initial
  begin
    pv = '0;
    quiet = '{default: 0};
    {mem_ready, mem_wr_idle, mem_rvalid, mem_rdata} = '0;
  end
  always @(posedge clk)
  begin
    for (int g = 0; g < 4; g++)
    begin
      longint        a;
      logic [AW-1:0] ad;
      ad = mem_addr[g*AW +: AW];
      a = (longint'(g) << AW) + longint'(ad);
      if (mem_write[g] && mem_ready[g])
      begin
        store[a] = mem_wdata[g*DW +: DW];
        quiet[g] <= 0;
      end
      else if (quiet[g] < 4)
        quiet[g] <= quiet[g] + 1;
      // idle only once writes have drained, never on the same edge
      mem_wr_idle[g] <= !mem_write[g] && quiet[g] >= 3;
      pv[g] <= mem_read[g] && mem_ready[g];
      pipe[g] <= (store.exists(a) ? store[a] : '1) ^ DW'(bad[g] && ad == 5);
      mem_rvalid[g] <= pv[g];
      // between words the bus inverts every cycle, so stale data never holds steady
      mem_rdata[g*DW +: DW] <= pv[g] ? pipe[g] : ~mem_rdata[g*DW +: DW];
      // slow paces the lower speed grade, fast the higher one
      mem_ready[g] <= $urandom_range(slow ? 3 : 1) == 0;
    end
  end
endmodule

// ===== tb/test_dqmt_top.sv
/*
  self-checking bench of the quad tester against the controller model.
  assumes blink and run counts shortened by parameter.
*/
`timescale 1ns/1ns
`include "dqmt_defs.svh"
module test_dqmt_top;
  localparam int AW = `DQMT_ADDR_W;
  localparam int DW = `DQMT_DATA_W;
  localparam int QN = 27;
  logic            clk, arst_n, key_n, quick_sel, slow, quick_run;
  logic [3:0]      bad, lamps, mem_write, mem_read;
  logic [3:0]      mem_ready, mem_wr_idle, mem_rvalid;
  logic [4*AW-1:0] mem_addr;
  logic [4*DW-1:0] mem_wdata, mem_rdata;
  int              n_errors, num_checks, cyc;
  int              nw [4];
  int              nr [4];
  int              nv [4];
  dqmt_top #(.RUN_CYC(100000), .BLINK_CYC(3)) i_dut
  (
    .clk(clk), .arst_n(arst_n), .test_start_key_n(key_n),
    .quick_sel(quick_sel), .result_lamp_socket_a(lamps[0]),
    .result_lamp_socket_b(lamps[1]), .result_lamp_socket_c(lamps[2]),
    .result_lamp_socket_d(lamps[3]), .mem_write(mem_write),
    .mem_read(mem_read), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ready(mem_ready), .mem_wr_idle(mem_wr_idle),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata)
  );
  dqmt_mem_model i_mem
  (
    .clk(clk), .slow(slow), .bad(bad), .mem_write(mem_write),
    .mem_read(mem_read), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ready(mem_ready), .mem_wr_idle(mem_wr_idle),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata)
  );
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [63:0] pat(input int a);
    return quick_run ? `DQMT_QUICK_PAT : {~AW'(a), 4'hF, AW'(a)};
  endfunction
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      give_verdict;
    end
  end
  always @(posedge clk)
  begin
    for (int g = 0; g < 4; g++)
    begin
      if (mem_write[g] && mem_ready[g])
      begin
        check(mem_addr[g*AW +: AW], AW'(nw[g]));
        check(mem_wdata[g*DW +: DW], pat(nw[g]));
        nw[g]++;
      end
      if (mem_read[g] && mem_ready[g])
      begin
        check(nw[g] == QN, 1'b1);
        check(mem_addr[g*AW +: AW], AW'(nr[g]));
        nr[g]++;
      end
      nv[g] += int'(mem_rvalid[g]);
    end
  end
  // quick run with a second press mid-run that must be ignored
  task automatic run(input logic q, input logic [3:0] b, input logic s);
    int         tog;
    logic [3:0] was;
    tog = 0;
    @(posedge clk);
    quick_sel <= q;
    bad <= b;
    slow <= s;
    quick_run = q;
    nw = '{default: 0};
    nr = '{default: 0};
    nv = '{default: 0};
    @(posedge clk);
    key_n <= 1'b0;
    for (int t = 0; t < 8 && mem_write !== 4'hF; t++)
      @(posedge clk) #1;
    check(mem_write, 4'hF);
    was = lamps;
    for (int t = 0; t < 4000 && nv.sum() < 4 * QN; t++)
    begin
      @(posedge clk);
      key_n <= !(t >= 20 && t < 26);
      #1;
      tog += int'(lamps !== was);
      was = lamps;
    end
    check(tog > 3, 1'b1);
    repeat (4) @(posedge clk);
    for (int t = 0; t < 10; t++)
    begin
      @(posedge clk) #1;
      check(lamps ^ b, 4'hF);
    end
    check(nw.sum(), 4 * QN);
  endtask
  initial
  begin
    {arst_n, slow, bad} = '0;
    {key_n, quick_sel, quick_run} = '1;
    void'($urandom(21470));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check(lamps, 4'h0);
    run(1'b1, 4'h0, 1'b0);
    run(1'b1, 4'hF, 1'b1);
    repeat (3) run(1'b1, 4'($urandom), 1'($urandom));
    // full-array run, cut short by a reset once its pattern is seen
    @(posedge clk);
    quick_sel <= 1'b0;
    quick_run = 1'b0;
    nw = '{default: 0};
    @(posedge clk);
    key_n <= 1'b0;
    for (int t = 0; t < 600 && nw[3] < 60; t++)
      @(posedge clk);
    check(nw[3] >= 60, 1'b1);
    arst_n <= 1'b0;
    key_n <= 1'b1;
    #1;
    check({lamps, mem_write, mem_read}, 12'h0);
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    run(1'b1, 4'h5, 1'b0);
    give_verdict;
  end
endmodule
